// file: fixed_frequency_sequencer.sv
`timescale 1ns/1ps
`include "fixed_frequency_sequencer_map.svh"

module fixed_frequency_sequencer
#(
    parameter int unsigned TICK_CYCLES = `SEQ_TICK_CYCLES // Clocks per second
)
(
    input wire logic aclk, // System clock, 40 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [5:0] digital_inputs, // Drive digital input pins
    input wire logic at_zero_speed, // Drive output frequency is zero
    output fixed_frequency_sequencer_pkg::drive_cmd_t drive_cmd, // Setpoint path command
    output logic relay_output_one, // Relay one
    output logic relay_output_two, // Relay two
    output logic transistor_output, // Transistor output
    output logic irq // Interrupt, active high level
);

    // Configuration registers
    logic [31:0] ctrl; // Mode, stop function, input assignments
    logic [7:0] direction_program_code; // One reverse bit per step
    logic [31:0] outfn; // Output function codes
    logic [3:0] irq_status; // Sticky events
    logic [3:0] irq_mask; // Enables
    logic [15:0] step_frequency_setpoints [8]; // Per-step setpoint
    logic [9:0] step_run_times [8]; // Per-step seconds, zero skips

    // Sequencer state
    fixed_frequency_sequencer_pkg::seq_state_t state; // Main state
    fixed_frequency_sequencer_pkg::seq_flags_t flags; // Indications
    logic [3:0] step; // Step index, 8 means past the end
    logic [9:0] remaining; // Seconds left in step
    logic [31:0] tick_cnt; // Time base divider
    logic tick; // One-second strobe
    logic [5:0] din; // Filtered inputs
    logic start_level; // Assigned start input level
    logic pause_level; // Assigned pause input level
    logic pause_seen; // Delayed pause for edge detection

    // Cycle events as single-cycle pulses
    logic ev_step_end;
    logic ev_cycle_end;
    logic ev_terminated;

    // AXI bookkeeping
    logic aw_held; // Write address captured
    logic w_held; // Write data captured
    logic [7:0] waddr; // Captured write address
    logic [31:0] wdata; // Captured write data
    logic [3:0] wstrb; // Captured strobes
    logic do_write; // Both halves present
    logic [31:0] rd_word; // Decoded read word
    logic rd_hit; // Read address mapped
    logic wr_hit; // Write address mapped

    wire [2:0] cycle_mode_select = ctrl[`SEQ_CTRL_MODE_LSB +: 3];
    wire stop_function_select = ctrl[`SEQ_CTRL_STOP_BIT];
    wire [2:0] start_input_assign = ctrl[`SEQ_CTRL_START_LSB +: 3];
    wire [2:0] pause_input_assign = ctrl[`SEQ_CTRL_PAUSE_LSB +: 3];
    wire continuous = (cycle_mode_select == `SEQ_MODE_CONT) ||
                      (cycle_mode_select == `SEQ_MODE_CONT_STEPS);
    wire stepped = (cycle_mode_select == `SEQ_MODE_STEPS) ||
                   (cycle_mode_select == `SEQ_MODE_CONT_STEPS);
    wire mode_valid = (cycle_mode_select >= `SEQ_MODE_ONCE) &&
                      (cycle_mode_select <= `SEQ_MODE_CONT_STEPS);

    pin_sync u_pin_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(digital_inputs),
        .levels(din)
    );

    // Pick the assigned inputs; unassigned (0 or above 6) reads as inactive
    always_comb
    begin
        start_level = 1'b0;
        pause_level = 1'b0;
        if (start_input_assign >= 3'h1 && start_input_assign <= 3'h6)
        begin
            start_level = din[start_input_assign - 3'h1];
        end
        if (pause_input_assign >= 3'h1 && pause_input_assign <= 3'h6)
        begin
            pause_level = din[pause_input_assign - 3'h1];
        end
    end

    // One-second time base; restarts at each step so the first second is whole
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state != fixed_frequency_sequencer_pkg::S_RUN)
        begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (!pause_level)
        begin
            tick <= (tick_cnt == TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h1;
        end
        else
        begin
            tick <= 1'b0;
        end
    end

    // Sequencer state machine
    always_ff @(posedge aclk)
    begin
        ev_step_end <= 1'b0;
        ev_cycle_end <= 1'b0;
        ev_terminated <= 1'b0;
        if (!aresetn)
        begin
            state <= fixed_frequency_sequencer_pkg::S_IDLE;
            step <= 4'h0;
            remaining <= 10'h000;
        end
        else if (state != fixed_frequency_sequencer_pkg::S_IDLE && !start_level)
        begin
            // Start withdrawn: stop the drive and drop the sequence at once
            state <= fixed_frequency_sequencer_pkg::S_IDLE;
            ev_terminated <= (state != fixed_frequency_sequencer_pkg::S_DONE);
        end
        else
        begin
            unique case (state)
                fixed_frequency_sequencer_pkg::S_IDLE:
                begin
                    // Level sensitive, so an input already high after reset starts too
                    if (start_level && mode_valid)
                    begin
                        step <= 4'h0;
                        state <= fixed_frequency_sequencer_pkg::S_SEEK;
                    end
                end
                fixed_frequency_sequencer_pkg::S_SEEK:
                begin
                    if (step[3])
                    begin
                        // Past the last step: cycle complete
                        ev_cycle_end <= 1'b1;
                        step <= 4'h0;
                        if (continuous)
                        begin
                            state <= fixed_frequency_sequencer_pkg::S_SEEK;
                        end
                        else
                        begin
                            state <= fixed_frequency_sequencer_pkg::S_DONE;
                        end
                    end
                    else if (step_run_times[step[2:0]] == 10'h000)
                    begin
                        step <= step + 4'h1;
                    end
                    else if (!pause_level)
                    begin
                        remaining <= step_run_times[step[2:0]];
                        state <= fixed_frequency_sequencer_pkg::S_RUN;
                    end
                end
                fixed_frequency_sequencer_pkg::S_RUN:
                begin
                    // Pause freezes the time base, so the step resumes where it stood
                    if (tick && !pause_level)
                    begin
                        if (remaining == 10'h001)
                        begin
                            ev_step_end <= 1'b1;
                            if (stepped)
                            begin
                                state <= fixed_frequency_sequencer_pkg::S_RAMP_ZERO;
                            end
                            else
                            begin
                                step <= step + 4'h1;
                                state <= fixed_frequency_sequencer_pkg::S_SEEK;
                            end
                        end
                        remaining <= remaining - 10'h001;
                    end
                end
                fixed_frequency_sequencer_pkg::S_RAMP_ZERO:
                begin
                    // Next step only once the drive reports standstill
                    if (at_zero_speed)
                    begin
                        step <= step + 4'h1;
                        state <= fixed_frequency_sequencer_pkg::S_SEEK;
                    end
                end
                fixed_frequency_sequencer_pkg::S_DONE:
                begin
                    // Held here until the start input goes low
                end
            endcase
        end
    end

    // Indications; step and cycle ends are stretched so a relay can see them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags <= '0;
            pause_seen <= 1'b0;
        end
        else
        begin
            pause_seen <= pause_level;
            flags.running <= (state != fixed_frequency_sequencer_pkg::S_IDLE) &&
                             (state != fixed_frequency_sequencer_pkg::S_DONE);
            flags.paused <= pause_level && (state != fixed_frequency_sequencer_pkg::S_IDLE);
            if (ev_step_end)
            begin
                flags.step_end <= 1'b1;
            end
            else if (state == fixed_frequency_sequencer_pkg::S_RUN ||
                     state == fixed_frequency_sequencer_pkg::S_IDLE)
            begin
                flags.step_end <= 1'b0;
            end
            if (ev_cycle_end)
            begin
                flags.cycle_end <= 1'b1;
            end
            else if (state == fixed_frequency_sequencer_pkg::S_RUN ||
                     state == fixed_frequency_sequencer_pkg::S_IDLE)
            begin
                flags.cycle_end <= 1'b0;
            end
        end
    end

    // Map a function code to the indication it shows
    function automatic logic out_select(input logic [4:0] code,
                                        input fixed_frequency_sequencer_pkg::seq_flags_t f);
        logic v;
        v = 1'b0;
        if (code == `SEQ_FN_RUNNING) v = f.running;
        if (code == `SEQ_FN_STEP_END) v = f.step_end;
        if (code == `SEQ_FN_CYCLE_END) v = f.cycle_end;
        if (code == `SEQ_FN_PAUSED) v = f.paused;
        return v;
    endfunction : out_select

    // Output pins and setpoint command, all registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            relay_output_one <= 1'b0;
            relay_output_two <= 1'b0;
            transistor_output <= 1'b0;
            drive_cmd <= '0;
        end
        else
        begin
            relay_output_one <= out_select(outfn[`SEQ_OUTFN_RELAY_ONE_LSB +: 5], flags);
            relay_output_two <= out_select(outfn[`SEQ_OUTFN_RELAY_TWO_LSB +: 5], flags);
            transistor_output <= out_select(outfn[`SEQ_OUTFN_TO_LSB +: 5], flags);
            // Active overrides every other setpoint and start source
            drive_cmd.active <= (state != fixed_frequency_sequencer_pkg::S_IDLE) &&
                                (state != fixed_frequency_sequencer_pkg::S_DONE);
            drive_cmd.run <= (state == fixed_frequency_sequencer_pkg::S_RUN);
            drive_cmd.stop_ramp <= stop_function_select;
            drive_cmd.reverse <= direction_program_code[step[2:0]];
            drive_cmd.freq <= step_frequency_setpoints[step[2:0]];
        end
    end

    // AXI write channel: address and data are taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = (waddr[1:0] == 2'h0) && (waddr <= `SEQ_IRQ_MASK_OFS ||
                    (waddr >= `SEQ_FREQ_BASE && waddr < `SEQ_TIME_BASE + 8'h20));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= 8'h00;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                waddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                wdata <= s_axi_wdata;
                wstrb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2; // SLVERR on unmapped
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction : merge

    // Configuration register writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= `SEQ_CTRL_RST;
            direction_program_code <= `SEQ_DIR_RST;
            outfn <= `SEQ_OUTFN_RST;
            irq_mask <= 4'h0;
        end
        else if (do_write)
        begin
            if (waddr == `SEQ_CTRL_OFS) ctrl <= merge(ctrl, wdata, wstrb);
            if (waddr == `SEQ_DIR_OFS && wstrb[0]) direction_program_code <= wdata[7:0];
            if (waddr == `SEQ_OUTFN_OFS) outfn <= merge(outfn, wdata, wstrb);
            if (waddr == `SEQ_IRQ_MASK_OFS && wstrb[0]) irq_mask <= wdata[3:0];
        end
    end

    // Per-step setpoint and run time tables
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_step
            logic [31:0] fw;
            logic [31:0] tw;
            assign fw = merge({16'h0000, step_frequency_setpoints[g]}, wdata, wstrb);
            assign tw = merge({22'h000000, step_run_times[g]}, wdata, wstrb);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    step_frequency_setpoints[g] <= `SEQ_FREQ_RST;
                    step_run_times[g] <= `SEQ_TIME_RST;
                end
                else if (do_write)
                begin
                    if (waddr == `SEQ_FREQ_BASE + 8'(4 * g)) step_frequency_setpoints[g] <= fw[15:0];
                    if (waddr == `SEQ_TIME_BASE + 8'(4 * g)) step_run_times[g] <= tw[9:0];
                end
            end
        end
    endgenerate

    // Sticky events; a new event in the clearing cycle survives the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 4'h0;
        end
        else
        begin
            irq_status <= (irq_status & ~((do_write && waddr == `SEQ_IRQ_STATUS_OFS &&
                           wstrb[0]) ? wdata[3:0] : 4'h0)) |
                          {pause_level && !pause_seen && flags.running,
                           ev_terminated, ev_cycle_end, ev_step_end};
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read decode
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = (s_axi_araddr[1:0] == 2'h0);
        if (s_axi_araddr == `SEQ_CTRL_OFS) rd_word = ctrl;
        else if (s_axi_araddr == `SEQ_DIR_OFS) rd_word = {24'h000000, direction_program_code};
        else if (s_axi_araddr == `SEQ_OUTFN_OFS) rd_word = outfn;
        else if (s_axi_araddr == `SEQ_STATUS_OFS)
            rd_word = {16'h0000, remaining[7:0], 1'b0, step[2:0], flags};
        else if (s_axi_araddr == `SEQ_IRQ_STATUS_OFS) rd_word = {28'h0000000, irq_status};
        else if (s_axi_araddr == `SEQ_IRQ_MASK_OFS) rd_word = {28'h0000000, irq_mask};
        else if (s_axi_araddr >= `SEQ_FREQ_BASE && s_axi_araddr < `SEQ_TIME_BASE)
            rd_word = {16'h0000, step_frequency_setpoints[s_axi_araddr[4:2]]};
        else if (s_axi_araddr >= `SEQ_TIME_BASE && s_axi_araddr < `SEQ_TIME_BASE + 8'h20)
            rd_word = {22'h000000, step_run_times[s_axi_araddr[4:2]]};
        else rd_hit = 1'b0;
    end

    // AXI read channel, one read at a time
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : fixed_frequency_sequencer

// file: fixed_frequency_sequencer_map.svh
`ifndef FIXED_FREQUENCY_SEQUENCER_MAP_SVH
`define FIXED_FREQUENCY_SEQUENCER_MAP_SVH

// Register byte offsets
`define SEQ_CTRL_OFS 8'h00
`define SEQ_DIR_OFS 8'h04
`define SEQ_OUTFN_OFS 8'h08
`define SEQ_STATUS_OFS 8'h0c
`define SEQ_IRQ_STATUS_OFS 8'h10
`define SEQ_IRQ_MASK_OFS 8'h14
`define SEQ_FREQ_BASE 8'h20
`define SEQ_TIME_BASE 8'h40

// Control register fields
`define SEQ_CTRL_MODE_LSB 0
`define SEQ_CTRL_STOP_BIT 4
`define SEQ_CTRL_START_LSB 8
`define SEQ_CTRL_PAUSE_LSB 12

// Output function field positions
`define SEQ_OUTFN_RELAY_ONE_LSB 0
`define SEQ_OUTFN_RELAY_TWO_LSB 8
`define SEQ_OUTFN_TO_LSB 16

// Interrupt status bits
`define SEQ_IRQ_STEP_END 0
`define SEQ_IRQ_CYCLE_END 1
`define SEQ_IRQ_TERMINATED 2
`define SEQ_IRQ_PAUSED 3

// Reset values
`define SEQ_CTRL_RST 32'h0000_0000
`define SEQ_DIR_RST 8'h00
`define SEQ_OUTFN_RST 32'h0000_0000
`define SEQ_TIME_RST 10'h000
`define SEQ_FREQ_RST 16'h0000

// Output function codes
`define SEQ_FN_RUNNING 5'h10
`define SEQ_FN_STEP_END 5'h11
`define SEQ_FN_CYCLE_END 5'h12
`define SEQ_FN_PAUSED 5'h13

// Cycle mode codes
`define SEQ_MODE_ONCE 3'h1
`define SEQ_MODE_CONT 3'h2
`define SEQ_MODE_STEPS 3'h3
`define SEQ_MODE_CONT_STEPS 3'h4

// Timing: one-second time base at a 25 ns clock
`define SEQ_TICK_PERIOD_NS 1000000000
`define SEQ_CLK_PERIOD_NS 25
`define SEQ_TICK_CYCLES (`SEQ_TICK_PERIOD_NS / `SEQ_CLK_PERIOD_NS)

`endif

// file: fixed_frequency_sequencer_pkg.sv
package fixed_frequency_sequencer_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_SEEK,
        S_RUN,
        S_RAMP_ZERO,
        S_DONE
    } seq_state_t;

    // Command to the motor setpoint path
    typedef struct packed {
        logic active;       // Sequencer owns setpoint and start
        logic run;          // Drive runs on the setpoint below
        logic reverse;      // Reverse rotating direction
        logic stop_ramp;    // Stop function: 1 ramp, 0 coast
        logic [15:0] freq;  // Frequency setpoint
    } drive_cmd_t;

    // Sequencer status indications
    typedef struct packed {
        logic running;
        logic step_end;
        logic cycle_end;
        logic paused;
    } seq_flags_t;

endpackage : fixed_frequency_sequencer_pkg

// file: pin_sync.sv
`timescale 1ns/1ps

// Three-stage pin synchroniser; a change is accepted once stages two and three agree
module pin_sync
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [5:0] pins, // Raw digital inputs
    output logic [5:0] levels // Filtered levels
);

    genvar i;
    generate
        for (i = 0; i < 6; i++)
        begin : g_bit
            logic s1; // Only ever read by s2
            logic s2;
            logic s3;

            // Shift chain; the agreement check rejects single-cycle glitches
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    levels[i] <= 1'b0;
                end
                else
                begin
                    s1 <= pins[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                    begin
                        levels[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule : pin_sync

// file: fixed_frequency_sequencer_checker.sv
`timescale 1ns/1ps

// Bus handshakes and the setpoint command seen from the top ports
module seq_checker
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire fixed_frequency_sequencer_pkg::drive_cmd_t drive_cmd, // Setpoint command
    input wire logic irq // Interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A pending response blocks both write halves
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    run_owned_a: assert property (drive_cmd.run |-> drive_cmd.active)
        else $error("run without ownership");
    stop_drop_a: assert property ($fell(drive_cmd.active) |-> !drive_cmd.run)
        else $error("run left on after release");
    reset_quiet_a: assert property (!$past(aresetn) |-> drive_cmd == '0 && !irq)
        else $error("outputs not cleared by reset");
endmodule : seq_checker

bind fixed_frequency_sequencer seq_checker chk (.*);

// file: drive_model.sv
`timescale 1ns/1ps

// Motor side: standstill shows some cycles after the run command drops
module drive_model
#(
    parameter int DECEL = 6 // Countdown length; standstill shows DECEL + 1 cycles after stop
)
(
    input wire logic aclk, // Clock
    input wire fixed_frequency_sequencer_pkg::drive_cmd_t drive_cmd, // Command
    output logic at_zero_speed = 1'h1 // Standstill flag
);
    int cnt = 0; // Deceleration countdown
    // Run reloads the countdown so standstill never shows while turning
    always_ff @(posedge aclk)
    begin
        cnt <= drive_cmd.run ? DECEL : (cnt > 0 ? cnt - 1 : 0);
        at_zero_speed <= !drive_cmd.run && cnt == 0;
    end
endmodule : drive_model

// file: fixed_frequency_sequencer_tb.sv
`timescale 1ns/1ps
`include "fixed_frequency_sequencer_map.svh"

// Compares a value with its expectation and counts the outcome
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end

module fixed_frequency_sequencer_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, at_zero_speed, relay_output_one, relay_output_two;
    logic transistor_output, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
    logic [5:0] digital_inputs = 6'h00; // Start on pin 0, pause on pin 1
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] held; // Setpoint seen when pause began
    fixed_frequency_sequencer_pkg::drive_cmd_t drive_cmd;
    int n_fail = 0, check_count = 0, cyc = 0;

    // Short second so a step lasts ten clocks
    fixed_frequency_sequencer #(.TICK_CYCLES(10)) dut (.*);
    drive_model partner (.aclk(aclk), .drive_cmd(drive_cmd), .at_zero_speed(at_zero_speed));

    initial forever #12.5 aclk = ~aclk;

    // Cuts a hang short; the tests need far fewer cycles
    always @(posedge aclk) if (++cyc == 5000) begin n_fail++; conclude(); end

    // Offers both write halves and waits for the response
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h0;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h1; // Late ready: the response must wait for it
        @(posedge aclk);
        `CHK(s_axi_bresp, 2'h0)
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h0;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h1; // Late ready: the data must stand meanwhile
        @(posedge aclk);
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
    endtask : rd

    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`SEQ_CTRL_OFS, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, 2'h2); // Unmapped place
        for (int i = 0; i < 8; i++) wr(`SEQ_FREQ_BASE + 8'(4 * i), 32'h100 + i);
        wr(`SEQ_TIME_BASE, 32'h1);
        wr(`SEQ_TIME_BASE + 8'h18, 32'h1);
        wr(`SEQ_DIR_OFS, 32'hc0);
        wr(`SEQ_OUTFN_OFS, 32'h0013_1110);
        wr(`SEQ_IRQ_MASK_OFS, 32'h2);
        wr(`SEQ_CTRL_OFS, 32'h2101);
        digital_inputs <= 6'h01;
        while (!drive_cmd.run) @(posedge aclk);
        `CHK(drive_cmd.freq, 16'h0100)
        `CHK(drive_cmd.reverse, 1'h0)
        while (drive_cmd.freq != 16'h0106) @(posedge aclk);
        `CHK(drive_cmd.reverse, 1'h1)
        `CHK(relay_output_one, 1'h1)
        while (relay_output_one) @(posedge aclk);
        `CHK(drive_cmd.active, 1'h0)
        `CHK(relay_output_two, 1'h1)
        `CHK(irq, 1'h1)
        rd(`SEQ_IRQ_STATUS_OFS, 32'h3, 2'h0);
        wr(`SEQ_IRQ_STATUS_OFS, 32'hf);
        `CHK(irq, 1'h0)
        digital_inputs <= 6'h00;
        repeat (8) @(posedge aclk);
        wr(`SEQ_CTRL_OFS, 32'h2102);
        digital_inputs <= 6'h01;
        repeat (60) @(posedge aclk);
        `CHK(relay_output_one, 1'h1)
        digital_inputs <= 6'h03;
        repeat (8) @(posedge aclk);
        held = drive_cmd.freq;
        `CHK(transistor_output, 1'h1)
        repeat (20) @(posedge aclk);
        `CHK(drive_cmd.freq, held)
        repeat (20) @(posedge aclk);
        `CHK(drive_cmd.freq, held)
        digital_inputs <= 6'h01;
        repeat (8) @(posedge aclk);
        `CHK(drive_cmd.freq, held)
        digital_inputs <= 6'h00;
        repeat (8) @(posedge aclk);
        `CHK(drive_cmd.active, 1'h0)
        `CHK(relay_output_one, 1'h0)
        rd(`SEQ_IRQ_STATUS_OFS, 32'hf, 2'h0);
        wr(`SEQ_CTRL_OFS, 32'h2113);
        digital_inputs <= 6'h01;
        while (!drive_cmd.run) @(posedge aclk);
        `CHK(drive_cmd.freq, 16'h0100)
        while (drive_cmd.run) @(posedge aclk);
        `CHK(drive_cmd.active, 1'h1)
        while (!drive_cmd.run) @(posedge aclk);
        `CHK(drive_cmd.freq, 16'h0106)
        conclude();
    end
endmodule : fixed_frequency_sequencer_tb
